// file: core/synth_regs_pkg.sv
package synth_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] FB_LOW_WR_INDEX = 8'h2a;
  localparam logic [7:0] FB_MID_WR_INDEX = 8'h2b;
  localparam logic [7:0] FB_TOP_WR_INDEX = 8'h2c;
  localparam logic [7:0] REF_LOW_WR_INDEX = 8'h2d;
  localparam logic [7:0] REF_HIGH_WR_INDEX = 8'h2e;
  localparam logic [7:0] TRIM_WR_INDEX = 8'h2f;
  localparam logic [7:0] FB_LOW_RD_INDEX = 8'hda;
  localparam logic [7:0] FB_MID_RD_INDEX = 8'hdb;
  localparam logic [7:0] FB_TOP_RD_INDEX = 8'hdc;
  localparam logic [7:0] REF_LOW_RD_INDEX = 8'hdd;
  localparam logic [7:0] REF_HIGH_RD_INDEX = 8'hde;
  localparam logic [7:0] TRIM_RD_INDEX = 8'hdf;
  localparam logic [7:0] GEN_ENABLE_INDEX = 8'h30;
  localparam logic [7:0] GEN_RESET_INDEX = 8'h31;
  localparam logic [7:0] EVENT_STATUS_INDEX = 8'h32;
  localparam logic [7:0] EVENT_MASK_INDEX = 8'h33;

  // Address layout
  localparam int INDEX_LSB = 2;
  localparam int INDEX_WIDTH = 8;

  // Top feedback divider byte fields
  localparam int TOP_PLL_ENABLE_BIT = 7;
  localparam int TOP_LOCK_BIT = 6;
  localparam int TOP_CP_ENABLE_BIT = 5;
  localparam int TOP_MSB_WIDTH = 2;

  // General enable and general reset register fields
  localparam int GEN_PLL_ENABLE_BIT = 2;
  localparam int GEN_VCO_ENABLE_BIT = 3;
  localparam int GEN_RESET_BIT = 0;

  // Oscillator trim fields
  localparam int TRIM_NR_WIDTH = 2;
  localparam int TRIM_MIX_LSB = 2;
  localparam int TRIM_MIX_WIDTH = 6;

  // Event status bits
  localparam int EVENT_WIDTH = 4;
  localparam int EV_LOCK_GAINED = 0;
  localparam int EV_LOCK_LOST = 1;
  localparam int EV_FB_APPLIED = 2;
  localparam int EV_REF_APPLIED = 3;

  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [17:0] FB_VALUE_RESET = 18'h0_0000;
  localparam logic [15:0] REF_VALUE_RESET = 16'h0000;
  localparam logic [3:0] EVENT_RESET = 4'h0;

  // Analog control levels driven toward the synthesiser
  typedef struct packed {
    logic pll_run;
    logic charge_pump_enable;
    logic vco_enable;
    logic [TRIM_MIX_WIDTH-1:0] mixer_linearity_trim;
    logic [TRIM_NR_WIDTH-1:0] neg_resistance_select;
  } synth_ctrl_type;

endpackage : synth_regs_pkg

// file: core/pll_vco_control_registers.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module pll_vco_control_registers
  import synth_regs_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Synthesiser side
  input wire logic synth_lock_flag,
  output logic [17:0] feedback_divide_value,
  output logic [15:0] reference_divide_value,
  output synth_ctrl_type synth_ctrl,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Index from a word address; upper bits must be clear for a hit
  function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] index);
    hits = (addr[INDEX_LSB +: INDEX_WIDTH] == index) && (addr[1:0] == 2'b00)
      && ((addr >> (INDEX_LSB + INDEX_WIDTH)) == '0);
  endfunction : hits

  logic [7:0] fb_low;
  logic [7:0] fb_mid;
  logic [7:0] fb_top;
  logic [7:0] ref_low;
  logic [7:0] ref_high;
  logic [7:0] trim;
  logic [7:0] gen_enable;
  logic [EVENT_WIDTH-1:0] event_status;
  logic [EVENT_WIDTH-1:0] event_mask;
  logic lock_prev;
  logic mapped;
  logic [7:0] read_byte;
  logic write_fire;
  logic [7:0] wbyte;

  // Write happens only at the edge where the access phase completes
  assign write_fire = psel && penable && pready && pwrite;
  assign wbyte = pwdata[7:0];

  // Read mux and map check; readback reuses written bytes
  always_comb begin
    mapped = 1'b1;
    read_byte = BYTE_RESET;
    if (hits(paddr, FB_LOW_RD_INDEX)) begin
      read_byte = fb_low;
    end else if (hits(paddr, FB_MID_RD_INDEX)) begin
      read_byte = fb_mid;
    end else if (hits(paddr, FB_TOP_RD_INDEX)) begin
      read_byte = fb_top;
      read_byte[TOP_LOCK_BIT] = synth_lock_flag;
    end else if (hits(paddr, REF_LOW_RD_INDEX)) begin
      read_byte = ref_low;
    end else if (hits(paddr, REF_HIGH_RD_INDEX)) begin
      read_byte = ref_high;
    end else if (hits(paddr, TRIM_RD_INDEX)) begin
      read_byte = trim;
    end else if (hits(paddr, GEN_ENABLE_INDEX)) begin
      read_byte = gen_enable;
    end else if (hits(paddr, EVENT_STATUS_INDEX)) begin
      read_byte = {4'h0, event_status};
    end else if (hits(paddr, EVENT_MASK_INDEX)) begin
      read_byte = {4'h0, event_mask};
    end else if (hits(paddr, FB_LOW_WR_INDEX) || hits(paddr, FB_MID_WR_INDEX)
        || hits(paddr, FB_TOP_WR_INDEX) || hits(paddr, REF_LOW_WR_INDEX)
        || hits(paddr, REF_HIGH_WR_INDEX) || hits(paddr, TRIM_WR_INDEX)
        || hits(paddr, GEN_RESET_INDEX)) begin
      read_byte = BYTE_RESET; // Write-only bytes read as zero
    end else begin
      mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake

  // One wait state; read data captured together with pready
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_byte};
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback divider

  // Lower bytes only stage; readback addresses never match here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fb_low <= BYTE_RESET;
      fb_mid <= BYTE_RESET;
      fb_top <= BYTE_RESET;
    end else if (write_fire) begin
      if (hits(paddr, FB_LOW_WR_INDEX)) begin
        fb_low <= wbyte;
      end
      if (hits(paddr, FB_MID_WR_INDEX)) begin
        fb_mid <= wbyte;
      end
      if (hits(paddr, FB_TOP_WR_INDEX)) begin
        fb_top <= wbyte;
      end
    end
  end

  // Running value moves only on a top byte write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      feedback_divide_value <= FB_VALUE_RESET;
    end else if (write_fire && hits(paddr, FB_TOP_WR_INDEX)) begin
      feedback_divide_value <= {wbyte[TOP_MSB_WIDTH-1:0], fb_mid, fb_low};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference divider

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ref_low <= BYTE_RESET;
      ref_high <= BYTE_RESET;
      reference_divide_value <= REF_VALUE_RESET;
    end else if (write_fire) begin
      if (hits(paddr, REF_LOW_WR_INDEX)) begin
        ref_low <= wbyte;
      end
      if (hits(paddr, REF_HIGH_WR_INDEX)) begin
        ref_high <= wbyte;
        reference_divide_value <= {wbyte, ref_low};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General enables and oscillator trim

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gen_enable <= BYTE_RESET;
    end else if (write_fire && hits(paddr, GEN_ENABLE_INDEX)) begin
      gen_enable <= wbyte;
    end
  end

  // General reset command wins over a trim write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trim <= BYTE_RESET;
    end else if (write_fire && hits(paddr, GEN_RESET_INDEX) && wbyte[GEN_RESET_BIT]) begin
      trim <= BYTE_RESET;
    end else if (write_fire && hits(paddr, TRIM_WR_INDEX)) begin
      trim <= wbyte;
    end
  end

  // Analog controls registered so every output comes from a flop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      synth_ctrl <= '0;
    end else begin
      synth_ctrl.pll_run <= fb_top[TOP_PLL_ENABLE_BIT] && gen_enable[GEN_PLL_ENABLE_BIT];
      synth_ctrl.charge_pump_enable <= fb_top[TOP_CP_ENABLE_BIT];
      synth_ctrl.vco_enable <= gen_enable[GEN_VCO_ENABLE_BIT];
      synth_ctrl.mixer_linearity_trim <= trim[TRIM_MIX_LSB +: TRIM_MIX_WIDTH];
      synth_ctrl.neg_resistance_select <= trim[TRIM_NR_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  logic [EVENT_WIDTH-1:0] event_set;

  // Lock edges and divider applications
  always_comb begin
    event_set = EVENT_RESET;
    event_set[EV_LOCK_GAINED] = synth_lock_flag && !lock_prev;
    event_set[EV_LOCK_LOST] = !synth_lock_flag && lock_prev;
    event_set[EV_FB_APPLIED] = write_fire && hits(paddr, FB_TOP_WR_INDEX);
    event_set[EV_REF_APPLIED] = write_fire && hits(paddr, REF_HIGH_WR_INDEX);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_prev <= 1'b0;
    end else begin
      lock_prev <= synth_lock_flag;
    end
  end

  // Write one to clear; a new event in the same cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      event_status <= EVENT_RESET;
    end else if (write_fire && hits(paddr, EVENT_STATUS_INDEX)) begin
      event_status <= (event_status & ~wbyte[EVENT_WIDTH-1:0]) | event_set;
    end else begin
      event_status <= event_status | event_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      event_mask <= EVENT_RESET;
    end else if (write_fire && hits(paddr, EVENT_MASK_INDEX)) begin
      event_mask <= wbyte[EVENT_WIDTH-1:0];
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

endmodule : pll_vco_control_registers

// file: bench/synth_regs_chk.sv
`timescale 1ns/1ps
module synth_regs_chk
  import synth_regs_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Synthesiser side
  input wire logic synth_lock_flag,
  input wire logic [17:0] feedback_divide_value,
  input wire logic [15:0] reference_divide_value,
  input wire synth_ctrl_type synth_ctrl,
  input wire logic irq
);
  ////////////////////////////////////////////////////////////////
  // Decoded transfer completions
  wire [7:0] idx = paddr[9:2];
  wire done = psel && penable && pready;
  wire top_wr = done && pwrite && idx == FB_TOP_WR_INDEX;
  wire ref_wr = done && pwrite && idx == REF_HIGH_WR_INDEX;
  // Upper address bits must be clear, else the index aliases
  wire mapped = paddr[1:0] == 2'b00 && paddr[ADDR_WIDTH-1:10] == '0 &&
    (idx inside {[8'h2a:8'h33], [8'hda:8'hdf]});
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  a_fb_top_only: assert property (!$stable(feedback_divide_value) |-> $past(top_wr))
    else $error("feedback divider moved without top write");
  a_ref_high_only: assert property (!$stable(reference_divide_value) |-> $past(ref_wr))
    else $error("reference divider moved without high write");
  a_fb_msb_load: assert property (top_wr |=> feedback_divide_value[17:16] == $past(pwdata[1:0]))
    else $error("feedback divider msbs wrong");
  a_cp_follow: assert property (top_wr |-> ##2 synth_ctrl.charge_pump_enable == $past(pwdata[5], 2))
    else $error("charge pump enable not following top write");
  a_pll_off: assert property (top_wr && !pwdata[7] |-> ##2 !synth_ctrl.pll_run)
    else $error("pll running with its enable clear");
  a_lock_live: assert property (done && !pwrite && idx == FB_TOP_RD_INDEX |-> prdata[6] == $past(synth_lock_flag))
    else $error("lock bit not live on readback");
  a_rb_no_write: assert property (done && pwrite && idx >= 8'hda |=> $stable(feedback_divide_value) &&
    $stable(reference_divide_value))
    else $error("readback write changed a divider");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata nonzero outside answer");
  // Main scenarios reached
  c_top_wr: cover property (top_wr);
  c_unmapped: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule : synth_regs_chk

// file: bench/pll_vco_control_registers_tb.sv
`timescale 1ns/1ps
module pll_vco_control_registers_tb;
  import synth_regs_pkg::*;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, synth_lock_flag = 0, lock = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 12;
  logic pready, pslverr, irq;
  logic [17:0] feedback_divide_value, fb_old;
  logic [15:0] reference_divide_value;
  synth_ctrl_type synth_ctrl;
  logic [7:0] rd, a, b, c, g, t;
  int n_fail = 0, checked = 0;
  pll_vco_control_registers dut_u (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .synth_lock_flag, .feedback_divide_value, .reference_divide_value, .synth_ctrl, .irq);
  ////////////////////////////////////////////////////////////////
  // Clock and lock input, the lock launched off the rising edge
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) synth_lock_flag <= lock;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; pready and read data taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(k < 20, 1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Dividers land after one edge, controls and irq two
  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask : settle
  task automatic end_sim();
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    for (int i = 'hda; i <= 'hdf; i++) begin
      apb(0, 8'(i), 0);
      chk(rd, 0);
    end
    repeat (16) begin
      a = rnd();
      b = rnd();
      c = rnd() & 8'ha3;
      g = rnd() & 8'h0c;
      t = rnd();
      lock <= t[0];
      fb_old = feedback_divide_value;
      apb(1, GEN_ENABLE_INDEX, g);
      apb(1, FB_LOW_WR_INDEX, a);
      apb(1, FB_MID_WR_INDEX, b);
      apb(1, FB_TOP_RD_INDEX, 8'hff);
      settle();
      chk(feedback_divide_value, fb_old);
      chk(synth_ctrl.vco_enable, g[3]);
      apb(1, FB_TOP_WR_INDEX, c);
      settle();
      chk(feedback_divide_value, {c[1:0], b, a});
      chk(synth_ctrl.charge_pump_enable, c[5]);
      chk(synth_ctrl.pll_run, c[7] & g[2]);
      apb(0, FB_MID_RD_INDEX, 0);
      chk(rd, b);
      apb(0, FB_TOP_RD_INDEX, 0);
      chk(rd, {c[7], t[0], c[5:0]});
      apb(1, REF_LOW_WR_INDEX, a);
      apb(1, REF_HIGH_WR_INDEX, b);
      apb(0, REF_LOW_RD_INDEX, 0);
      chk(rd, a);
      chk(reference_divide_value, {b, a});
      apb(1, TRIM_WR_INDEX, t);
      settle();
      chk({synth_ctrl.mixer_linearity_trim, synth_ctrl.neg_resistance_select}, t);
      apb(0, TRIM_RD_INDEX, 0);
      chk(rd, t);
      apb(1, GEN_RESET_INDEX, {7'h00, t[1]});
      apb(0, TRIM_RD_INDEX, 0);
      chk(rd, t[1] ? 8'h00 : t);
    end
    // Lone top write reuses the staged lower bytes
    apb(1, FB_TOP_WR_INDEX, 8'h03);
    settle();
    chk(feedback_divide_value, {2'b11, b, a});
    // Recommended mixer trim of all ones reaches the analog side
    apb(1, TRIM_WR_INDEX, 8'hfc);
    settle();
    chk(synth_ctrl.mixer_linearity_trim, 6'h3f);
    // Unmapped and write-only reads
    apb(0, 8'h40, 0);
    chk({err, rd}, 9'h100);
    apb(0, FB_LOW_WR_INDEX, 0);
    chk({err, rd}, 9'h000);
    // Event raised masked, then unmasked, then cleared
    apb(1, EVENT_MASK_INDEX, 0);
    apb(1, EVENT_STATUS_INDEX, 8'h0f);
    apb(1, FB_TOP_WR_INDEX, 8'h20);
    settle();
    apb(0, EVENT_STATUS_INDEX, 0);
    chk({irq, rd}, 9'h004);
    apb(1, EVENT_MASK_INDEX, 8'h04);
    settle();
    chk(irq, 1);
    apb(1, EVENT_STATUS_INDEX, 8'h04);
    settle();
    chk(irq, 0);
    end_sim();
  end
endmodule : pll_vco_control_registers_tb
bind pll_vco_control_registers synth_regs_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.ref_clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .synth_lock_flag, .feedback_divide_value,
  .reference_divide_value, .synth_ctrl, .irq);
